// ===== verilog/rlsc_consts.svh
// register indices, field positions, reset values and timing counts
// assumes byte address = 4 * register index on the Avalon bus
`ifndef RLSC_CONSTS_SVH
`define RLSC_CONSTS_SVH

`define RLSC_IDX_W 10
`define RLSC_IDX_LOAD 10'h000
`define RLSC_IDX_STATE 10'h081
`define RLSC_IDX_IE 10'h082
`define RLSC_IDX_EVT 10'h083
`define RLSC_IDX_ERR 10'h084
`define RLSC_IDX_CELL0 10'h085
`define RLSC_IDX_CELL1 10'h086
`define RLSC_IDX_CELL2 10'h087
`define RLSC_IDX_OVF 10'h088
`define RLSC_IDX_RRW 10'h089
`define RLSC_IDX_CTRL 10'h090

`define RLSC_EVT_LOS 0
`define RLSC_EVT_LCD 1
`define RLSC_EVT_ACT 2
`define RLSC_EVT_CRC 3
`define RLSC_EVT_OCD 4
`define RLSC_EVT_HCS 5
`define RLSC_EVT_XFER 6
`define RLSC_EVT_OVR 7

`define RLSC_OVF_EN_FIFO 0
`define RLSC_OVF_EN_CTL 1
`define RLSC_OVF_FIFO 4
`define RLSC_OVF_CTL 5

`define RLSC_CTRL_WHOLE_CELL_CRC_CHECK_EN 0
`define RLSC_CTRL_COMBINED 1
`define RLSC_CTRL_MASTER_IE 2

`define RLSC_ERR_W 8
`define RLSC_CELL_W 24
`define RLSC_RST_IE 7'h00
`define RLSC_RST_CTRL 3'h0
`define RLSC_RST_OVF_EN 2'h0
`define RLSC_RST_RRW 2'h0
`define RLSC_WEIGHT_ZERO 3'h4

`define RLSC_CLK_NS 25
`define RLSC_XFER_MAX_NS 300
`define RLSC_XFER_MAX_CYC (`RLSC_XFER_MAX_NS / `RLSC_CLK_NS)

`endif

// ===== verilog/rlsc_pkg.sv
// types shared by the receive link status and counter block
// assumes nothing beyond a SystemVerilog compiler
package rlsc_pkg;
    typedef enum logic [0:0] {
        RLSC_BUS_IDLE = 1'b0,
        RLSC_BUS_ACK = 1'b1
    } rlsc_bus_t;
    typedef logic [1:0] rlsc_rrw_t;
endpackage

// ===== verilog/rlsc_event_flag.sv
// vector of sticky flags, hardware set beats software clear
// assumes set and clear are single-cycle pulses on ref_clk
`timescale 1ns/1ps
module rlsc_event_flag #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [W-1:0] set,
    input wire logic [W-1:0] clr,
    output logic [W-1:0] flag_q
);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            flag_q <= '0;
        end else begin
            flag_q <= set | (flag_q & ~clr);
        end
    end
endmodule

// ===== verilog/rlsc_sat_counter.sv
// saturating event counter restarted at each interval boundary
// assumes restart and inc are sampled on ref_clk
`timescale 1ns/1ps
module rlsc_sat_counter #(
    parameter int W = 8
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic inc,
    output logic [W-1:0] count_q
);
    logic [W-1:0] count_d;
    wire logic [W-1:0] inc_w;
    wire logic full_w;

    assign inc_w = {{(W-1){1'b0}}, inc};
    assign full_w = &count_q;

    always_comb begin
        count_d = count_q;
        if (restart) begin
            count_d = inc_w;
        end else if (inc && !full_w) begin
            count_d = count_q + inc_w;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end
endmodule

// ===== verilog/rlsc_top.sv
// receive link status flags, snapshot counters and upstream weight
// assumes line-side inputs synchronous to ref_clk, Avalon-MM slave
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps
`include "rlsc_consts.svh"
module rlsc_top (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [11:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic signal_loss_state,
    input wire logic delineation_loss_state,
    input wire logic far_end_activity_state,
    input wire logic out_of_delineation_state,
    input wire logic header_check_sequence_err,
    input wire logic cell_crc_err,
    input wire logic cell_accepted,
    input wire logic upstream_fifo_overflow,
    input wire logic control_cell_overflow,
    output logic [1:0] arbitration_weight,
    output logic [2:0] arbitration_slots,
    output logic interrupt_out_n
);
    localparam int XFER_CYC = `RLSC_XFER_MAX_CYC;

    // ------------------------------------------------------------
    // bus handshake
    // ------------------------------------------------------------
    rlsc_pkg::rlsc_bus_t bus_q, bus_d;
    wire logic bus_req;
    wire logic accept;
    wire logic rd_acc;
    wire logic wr_acc;
    wire logic [`RLSC_IDX_W-1:0] idx;

    assign bus_req = avs_read | avs_write;
    assign accept = (bus_q == rlsc_pkg::RLSC_BUS_ACK) & bus_req;
    assign rd_acc = accept & avs_read;
    assign wr_acc = accept & avs_write;
    assign idx = avs_address[11:2];
    assign avs_waitrequest = bus_req & (bus_q != rlsc_pkg::RLSC_BUS_ACK);

    always_comb begin
        case (bus_q)
            rlsc_pkg::RLSC_BUS_IDLE: begin
                bus_d = bus_req ? rlsc_pkg::RLSC_BUS_ACK : rlsc_pkg::RLSC_BUS_IDLE;
            end
            rlsc_pkg::RLSC_BUS_ACK: begin
                bus_d = rlsc_pkg::RLSC_BUS_IDLE;
            end
            default: begin
                bus_d = rlsc_pkg::RLSC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_q <= rlsc_pkg::RLSC_BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic sel_load;
    wire logic sel_state;
    wire logic sel_ie;
    wire logic sel_evt;
    wire logic sel_err;
    wire logic sel_c0;
    wire logic sel_c1;
    wire logic sel_c2;
    wire logic sel_ovf;
    wire logic sel_rrw;
    wire logic sel_ctrl;

    assign sel_load = idx == `RLSC_IDX_LOAD;
    assign sel_state = idx == `RLSC_IDX_STATE;
    assign sel_ie = idx == `RLSC_IDX_IE;
    assign sel_evt = idx == `RLSC_IDX_EVT;
    assign sel_err = idx == `RLSC_IDX_ERR;
    assign sel_c0 = idx == `RLSC_IDX_CELL0;
    assign sel_c1 = idx == `RLSC_IDX_CELL1;
    assign sel_c2 = idx == `RLSC_IDX_CELL2;
    assign sel_ovf = idx == `RLSC_IDX_OVF;
    assign sel_rrw = idx == `RLSC_IDX_RRW;
    assign sel_ctrl = idx == `RLSC_IDX_CTRL;

    // ------------------------------------------------------------
    // software control registers
    // ------------------------------------------------------------
    logic [6:0] ie_q;
    logic [2:0] ctrl_q;
    logic [1:0] ovf_en_q;
    rlsc_pkg::rlsc_rrw_t rrw_q;
    wire logic wr_lo;
    wire logic whole_cell_crc_check_en_en;
    wire logic combined;
    wire logic master_ie;

    assign wr_lo = wr_acc & avs_byteenable[0];
    assign whole_cell_crc_check_en_en = ctrl_q[`RLSC_CTRL_WHOLE_CELL_CRC_CHECK_EN];
    assign combined = whole_cell_crc_check_en_en & ctrl_q[`RLSC_CTRL_COMBINED];
    assign master_ie = ctrl_q[`RLSC_CTRL_MASTER_IE];

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ie_q <= `RLSC_RST_IE;
            ctrl_q <= `RLSC_RST_CTRL;
            ovf_en_q <= `RLSC_RST_OVF_EN;
            rrw_q <= `RLSC_RST_RRW;
        end else begin
            if (wr_lo && sel_ie) begin
                ie_q <= avs_writedata[6:0];
            end
            if (wr_lo && sel_ctrl) begin
                ctrl_q <= avs_writedata[2:0];
            end
            if (wr_lo && sel_ovf) begin
                ovf_en_q <= avs_writedata[1:0];
            end
            if (wr_lo && sel_rrw) begin
                rrw_q <= avs_writedata[1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // state change detection
    // ------------------------------------------------------------
    wire logic [3:0] st_now;
    logic [3:0] st_prev_q;
    logic armed_q;
    wire logic [3:0] st_chg;

    assign st_now = {out_of_delineation_state, far_end_activity_state,
                     delineation_loss_state, signal_loss_state};
    // no change reported until a first sample was taken after reset
    assign st_chg = armed_q ? (st_now ^ st_prev_q) : 4'h0;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_prev_q <= 4'h0;
            armed_q <= 1'b0;
        end else begin
            st_prev_q <= st_now;
            armed_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // event flags
    // ------------------------------------------------------------
    logic [7:0] evt_q;
    logic [7:0] evt_set;
    wire logic [7:0] evt_clr;
    wire logic xfer_trig;

    assign xfer_trig = wr_acc & (sel_err | sel_c0 | sel_c1 | sel_c2 | sel_load);
    // clear only what the read reported; a flag set after the capture stays
    assign evt_clr = (rd_acc && sel_evt) ? avs_readdata[7:0] : 8'h00;

    always_comb begin
        evt_set = 8'h00;
        evt_set[`RLSC_EVT_LOS] = st_chg[0];
        evt_set[`RLSC_EVT_LCD] = st_chg[1];
        evt_set[`RLSC_EVT_ACT] = st_chg[2];
        evt_set[`RLSC_EVT_CRC] = cell_crc_err & whole_cell_crc_check_en_en;
        evt_set[`RLSC_EVT_OCD] = st_chg[3];
        evt_set[`RLSC_EVT_HCS] = header_check_sequence_err;
        evt_set[`RLSC_EVT_XFER] = xfer_trig;
        // overrun only if the pending transfer was not acknowledged now
        evt_set[`RLSC_EVT_OVR] = xfer_trig & evt_q[`RLSC_EVT_XFER]
                                 & ~evt_clr[`RLSC_EVT_XFER];
    end

    // latched independent of interrupt enables; crc flag only with the crc check switched on
    rlsc_event_flag #(.W(8)) u_evt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set(evt_set),
        .clr(evt_clr),
        .flag_q(evt_q)
    );

    // ------------------------------------------------------------
    // overflow flags
    // ------------------------------------------------------------
    logic [1:0] ovf_q;
    wire logic [1:0] ovf_set;
    wire logic [1:0] ovf_clr;

    assign ovf_set = {control_cell_overflow, upstream_fifo_overflow};
    assign ovf_clr = (rd_acc && sel_ovf) ? avs_readdata[`RLSC_OVF_CTL:`RLSC_OVF_FIFO] : 2'h0;

    rlsc_event_flag #(.W(2)) u_ovf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .set(ovf_set),
        .clr(ovf_clr),
        .flag_q(ovf_q)
    );

    // ------------------------------------------------------------
    // live counters and holding registers
    // ------------------------------------------------------------
    logic [`RLSC_ERR_W-1:0] err_cnt;
    logic [`RLSC_CELL_W-1:0] cell_cnt;
    logic [`RLSC_ERR_W-1:0] hold_err_q;
    logic [`RLSC_CELL_W-1:0] hold_cell_q;
    wire logic err_inc;

    // one increment per cell even with both errors present
    assign err_inc = combined ? (header_check_sequence_err | cell_crc_err)
                              : header_check_sequence_err;

    rlsc_sat_counter #(.W(`RLSC_ERR_W)) u_err (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(xfer_trig),
        .inc(err_inc),
        .count_q(err_cnt)
    );

    rlsc_sat_counter #(.W(`RLSC_CELL_W)) u_cell (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .restart(xfer_trig),
        .inc(cell_accepted),
        .count_q(cell_cnt)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            hold_err_q <= '0;
            hold_cell_q <= '0;
        end else if (xfer_trig) begin
            hold_err_q <= err_cnt;
            hold_cell_q <= cell_cnt;
        end
    end

    // ------------------------------------------------------------
    // interrupt and weight outputs
    // ------------------------------------------------------------
    wire logic [6:0] ie_eff;
    wire logic irq_d;

    // crc event enable needs the crc check itself switched on
    assign ie_eff = {ie_q[6:4], ie_q[3] & whole_cell_crc_check_en_en, ie_q[2:0]};
    assign irq_d = master_ie & ((|(evt_q[6:0] & ie_eff))
                                | (|(ovf_q & ovf_en_q)));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            interrupt_out_n <= 1'b1;
            arbitration_weight <= `RLSC_RST_RRW;
            arbitration_slots <= `RLSC_WEIGHT_ZERO;
        end else begin
            interrupt_out_n <= ~irq_d;
            arbitration_weight <= rrw_q;
            arbitration_slots <= (rrw_q == 2'h0) ? `RLSC_WEIGHT_ZERO : {1'b0, rrw_q};
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    wire logic [7:0] rd_byte;

    assign rd_byte = sel_evt ? evt_q :
                     sel_ie ? {1'h0, ie_q} :
                     sel_state ? {3'h0, st_now[3], 1'h0, st_now[2:0]} :
                     sel_err ? hold_err_q :
                     sel_c0 ? hold_cell_q[7:0] :
                     sel_c1 ? hold_cell_q[15:8] :
                     sel_c2 ? hold_cell_q[23:16] :
                     sel_ovf ? {2'h0, ovf_q, 2'h0, ovf_en_q} :
                     sel_rrw ? {6'h00, rrw_q} :
                     sel_ctrl ? {5'h00, ctrl_q} : 8'h00;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && bus_q == rlsc_pkg::RLSC_BUS_IDLE) begin
            avs_readdata <= {24'h00_0000, rd_byte};
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    a_los_event: assert property (armed_q && $past(rst_n) &&
        signal_loss_state != $past(signal_loss_state) |=> evt_q[0])
        else $error("signal loss change not flagged");
    a_ocd_event: assert property (armed_q && $past(rst_n) &&
        out_of_delineation_state != $past(out_of_delineation_state) |=> evt_q[4])
        else $error("delineation state change not flagged");
    a_evt_read_clear: assert property (rd_acc && sel_evt && evt_set == 8'h00
        |=> (evt_q & $past(avs_readdata[7:0])) == 8'h00)
        else $error("event flags not cleared by read");
    a_hcs_latch: assert property (header_check_sequence_err && ie_q == 7'h00
        |=> evt_q[5])
        else $error("header check flag depends on enable");
    a_xfer_flag: assert property (xfer_trig |=> evt_q[6] && !evt_q[7] ||
        $past(evt_q[6]))
        else $error("transfer flag not set");
    a_overrun_set: assert property (xfer_trig && evt_q[6] && !evt_clr[6]
        |=> evt_q[7])
        else $error("overrun not flagged");
    a_hold_load: assert property (xfer_trig |=> hold_err_q == $past(err_cnt)
        && hold_cell_q == $past(cell_cnt) && err_cnt <= 8'h01)
        else $error("holding registers not loaded");
    a_hold_steady: assert property (!xfer_trig |=> $stable(hold_cell_q)
        && $stable(hold_err_q))
        else $error("holding registers changed without transfer");
    a_err_saturate: assert property (err_cnt == 8'hFF && !xfer_trig
        |=> err_cnt == 8'hFF)
        else $error("error counter wrapped");
    a_err_once: assert property (combined && header_check_sequence_err
        && cell_crc_err && !xfer_trig && err_cnt < 8'hFE
        |=> err_cnt == $past(err_cnt) + 8'h01)
        else $error("combined error not counted once");
    a_irq_master: assert property (!master_ie [*2] |-> interrupt_out_n)
        else $error("interrupt without master enable");
    a_irq_low: assert property (irq_d |=> !interrupt_out_n)
        else $error("enabled flag did not pull interrupt low");
    a_weight_map: assert property (rrw_q == 2'h0 |=> arbitration_slots == 3'h4)
        else $error("weight zero code not mapped to four");
    a_bus_answer: assert property (bus_req && bus_q == rlsc_pkg::RLSC_BUS_IDLE
        |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not one cycle");
    a_xfer_bound: assert property (xfer_trig |-> ##[1:XFER_CYC]
        hold_cell_q == $past(cell_cnt, 1))
        else $error("holding valid too late");

    c_overrun: cover property (xfer_trig && evt_q[6]);
    c_err_full: cover property (err_cnt == 8'hFF);
    c_read_ovr: cover property (rd_acc && sel_evt && evt_q[7]);
    c_irq: cover property (!interrupt_out_n);
endmodule

// ===== tb/rlsc_top_test.sv
// self-checking bench for the receive link status and counter block
// assumes rlsc_top as Avalon-MM slave with one wait cycle per access
`timescale 1ns/1ps
`include "rlsc_consts.svh"
module rlsc_top_test;
    localparam logic [4:0] P_HCS = 5'h01;
    localparam logic [4:0] P_CRC = 5'h02;
    localparam logic [4:0] P_ACC = 5'h04;
    localparam logic [4:0] P_FIFO = 5'h08;
    localparam logic [4:0] P_CTL = 5'h10;
    logic ref_clk;
    logic rst_n;
    logic [11:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [3:0] state_in;
    logic [4:0] pulse_in;
    logic [1:0] arbitration_weight;
    logic [2:0] arbitration_slots;
    logic interrupt_out_n;
    logic wait_s;
    logic [31:0] rdata_s;
    logic [31:0] rd;
    int errors;
    int comparisons;
    int cycles;

    rlsc_top DUT (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .signal_loss_state(state_in[0]),
        .delineation_loss_state(state_in[1]),
        .far_end_activity_state(state_in[2]),
        .out_of_delineation_state(state_in[3]),
        .header_check_sequence_err(pulse_in[0]),
        .cell_crc_err(pulse_in[1]),
        .cell_accepted(pulse_in[2]),
        .upstream_fifo_overflow(pulse_in[3]),
        .control_cell_overflow(pulse_in[4]),
        .arbitration_weight(arbitration_weight),
        .arbitration_slots(arbitration_slots),
        .interrupt_out_n(interrupt_out_n)
    );

    // ----------------------------------------
    // clock, settled-value sampling, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    always @(negedge ref_clk) begin
        wait_s = avs_waitrequest;
        rdata_s = avs_readdata;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            errors++;
            $display("Error timeout expected finish seen hang");
            complete_run();
        end
    end

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %0h seen %0h", name, exp, got);
        end
    endtask

    // one Avalon access, held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] data);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h000000, data};
        do @(posedge ref_clk); while (wait_s);
        rd = rdata_s;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string name);
        bus(1'b0, idx, 8'h00);
        check(name, exp, rd);
    endtask

    task automatic pulse(input logic [4:0] m, input int n);
        repeat (n) begin
            @(posedge ref_clk);
            pulse_in <= m;
            @(posedge ref_clk);
            pulse_in <= 5'h00;
        end
    endtask

    task automatic settle();
        repeat (3) @(negedge ref_clk);
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        for (int i = 'h083; i <= 'h089; i++) begin
            rd_chk(10'(i), 32'h0, "reset value");
        end
        rd_chk(10'h0FF, 32'h0, "unmapped read");
        settle();
        check("reset slots", 32'h4, arbitration_slots);
        check("reset irq", 32'h1, interrupt_out_n);
        $display("test reset done");
    endtask

    task automatic t_state();
        for (int i = 0; i < 4; i++) begin
            @(posedge ref_clk);
            state_in <= state_in ^ (4'h1 << i);
            rd_chk(`RLSC_IDX_EVT, 32'h1 << (i == 3 ? 4 : i), "state event");
            rd_chk(`RLSC_IDX_EVT, 32'h0, "state event cleared");
        end
        rd_chk(`RLSC_IDX_STATE, 32'h17, "live state");
        $display("test state done");
    endtask

    task automatic t_errflags();
        pulse(P_HCS | P_CRC, 1);
        rd_chk(`RLSC_IDX_EVT, 32'h20, "flags crc check off");
        bus(1'b1, `RLSC_IDX_CTRL, 8'h01);
        pulse(P_CRC, 1);
        rd_chk(`RLSC_IDX_EVT, 32'h08, "crc flag");
        rd_chk(`RLSC_IDX_EVT, 32'h00, "crc flag cleared");
        $display("test error flags done");
    endtask

    task automatic t_xfer();
        logic [9:0] trig [5] = '{`RLSC_IDX_LOAD, `RLSC_IDX_ERR, `RLSC_IDX_CELL0,
                                 `RLSC_IDX_CELL1, `RLSC_IDX_CELL2};
        bus(1'b1, `RLSC_IDX_CTRL, 8'h00);
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        bus(1'b0, `RLSC_IDX_EVT, 8'h00);
        pulse(P_HCS | P_ACC, 3);
        pulse(P_ACC, 2);
        pulse(P_CRC, 1);
        bus(1'b1, `RLSC_IDX_ERR, 8'h55);
        rd_chk(`RLSC_IDX_ERR, 32'h3, "hcs count");
        rd_chk(`RLSC_IDX_CELL0, 32'h5, "cell low");
        rd_chk(`RLSC_IDX_CELL1, 32'h0, "cell mid");
        rd_chk(`RLSC_IDX_CELL2, 32'h0, "cell high");
        rd_chk(`RLSC_IDX_EVT, 32'h60, "transfer flag");
        pulse(P_HCS, 2);
        rd_chk(`RLSC_IDX_ERR, 32'h3, "held count");
        rd_chk(`RLSC_IDX_EVT, 32'h20, "hcs flag again");
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, trig[i], 8'h00);
            rd_chk(`RLSC_IDX_EVT, 32'h40, "trigger");
        end
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        bus(1'b1, `RLSC_IDX_CELL2, 8'h00);
        rd_chk(`RLSC_IDX_EVT, 32'hC0, "overrun");
        rd_chk(`RLSC_IDX_EVT, 32'h00, "overrun cleared");
        rd_chk(`RLSC_IDX_ERR, 32'h0, "restarted count");
        $display("test transfer done");
    endtask

    task automatic t_counts();
        bus(1'b1, `RLSC_IDX_CTRL, 8'h03);
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        pulse(P_HCS | P_CRC, 1);
        pulse(P_CRC, 1);
        pulse(P_HCS, 1);
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        rd_chk(`RLSC_IDX_ERR, 32'h3, "combined count");
        bus(1'b1, `RLSC_IDX_CTRL, 8'h00);
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        pulse(P_HCS | P_ACC, 300);
        bus(1'b1, `RLSC_IDX_LOAD, 8'h00);
        rd_chk(`RLSC_IDX_ERR, 32'hFF, "saturated count");
        rd_chk(`RLSC_IDX_CELL0, 32'h2C, "cell low");
        rd_chk(`RLSC_IDX_CELL1, 32'h01, "cell mid");
        bus(1'b0, `RLSC_IDX_EVT, 8'h00);
        $display("test counts done");
    endtask

    task automatic t_irq();
        bus(1'b1, `RLSC_IDX_IE, 8'h20);
        pulse(P_HCS, 1);
        settle();
        check("irq master off", 32'h1, interrupt_out_n);
        bus(1'b1, `RLSC_IDX_CTRL, 8'h04);
        settle();
        check("irq enabled flag", 32'h0, interrupt_out_n);
        bus(1'b0, `RLSC_IDX_EVT, 8'h00);
        settle();
        check("irq after clear", 32'h1, interrupt_out_n);
        bus(1'b1, `RLSC_IDX_IE, 8'h00);
        bus(1'b1, `RLSC_IDX_OVF, 8'h03);
        pulse(P_FIFO, 1);
        settle();
        check("fifo overflow irq", 32'h0, interrupt_out_n);
        rd_chk(`RLSC_IDX_OVF, 32'h13, "fifo overflow");
        rd_chk(`RLSC_IDX_OVF, 32'h03, "fifo overflow cleared");
        pulse(P_CTL, 1);
        settle();
        check("control overflow irq", 32'h0, interrupt_out_n);
        rd_chk(`RLSC_IDX_OVF, 32'h23, "control overflow");
        bus(1'b1, `RLSC_IDX_OVF, 8'h00);
        bus(1'b1, `RLSC_IDX_CTRL, 8'h00);
        $display("test interrupt done");
    endtask

    task automatic t_weight();
        for (int c = 1; c <= 4; c++) begin
            bus(1'b1, `RLSC_IDX_RRW, 8'(c % 4));
            settle();
            check("weight", 32'(c % 4), arbitration_weight);
            check("slots", 32'(c), arbitration_slots);
            rd_chk(`RLSC_IDX_RRW, 32'(c % 4), "weight reg");
        end
        $display("test weight done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'b0;
        avs_address = 12'h000;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        state_in = 4'h0;
        pulse_in = 5'h00;
        errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (6) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_state();
        t_errflags();
        t_xfer();
        t_counts();
        t_irq();
        t_weight();
        complete_run();
    end
endmodule
